//--- verilog/antenna_supervisor_pkg.sv
// Package for the active antenna supervisor: register map, fields, codes and counts.
// Assumes a single 20 MHz clock and a plain word-wide register port.
package antenna_supervisor_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIMER_W = 24;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] TIMEOUT_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] CAPS_OFFSET = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 8'h14;

  // Feature enables, one bit each, in capability order.
  typedef struct packed {
    logic short_auto_recovery_enable;
    logic power_down_on_short;
    logic open_detect_enable;
    logic short_detect_enable;
    logic feed_voltage_control_enable;
  } feature_cfg_t;

  localparam int CFG_W = $bits(feature_cfg_t);
  localparam feature_cfg_t CFG_RESET = '0;
  localparam logic CFG_ON = 1'b1;

  // Reported antenna status codes.
  typedef enum logic [1:0] {
    FEED_INIT = 2'h0,
    FEED_OK = 2'h1,
    FEED_SHORT = 2'h2,
    FEED_OPEN = 2'h3
  } feed_status_t;

  // Kind of report on the report port.
  typedef enum logic {
    REPORT_CAPABILITY = 1'b0,
    REPORT_STATUS = 1'b1
  } report_kind_t;

  typedef struct packed {
    logic valid;
    report_kind_t kind;
    feed_status_t status;
    feature_cfg_t caps;
  } feed_report_t;

  // Interrupt event bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_STATUS_CHANGE = 0;
  localparam int IRQ_SHORT_SEEN = 1;
  localparam int IRQ_RECOVERED = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Status register field positions.
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_POWER_BIT = 2;
  localparam int STAT_CUT_BIT = 3;

  // Recovery timeout and retest settling, in clock cycles.
  localparam int CLK_HZ = 20_000_000;
  localparam int RECOVERY_TIMEOUT_MS = 1000;
  localparam logic [TIMER_W-1:0] RECOVERY_CYCLES_RESET =
    TIMER_W'(longint'(CLK_HZ) / 1000 * RECOVERY_TIMEOUT_MS / 2);
  localparam int RETEST_SETTLE_NS = 1000;
  localparam logic [TIMER_W-1:0] RETEST_SETTLE_CYCLES =
    TIMER_W'((RETEST_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

endpackage

//--- verilog/supervisor_timer.sv
// One-shot down counter used for the recovery timeout and the retest settle time.
// Assumes the caller holds start for one cycle with the wanted count on limit.
module supervisor_timer
  import antenna_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic [TIMER_W-1:0] limit,
  // Result
  output logic expired
);

  logic [TIMER_W-1:0] count_reg;
  logic [TIMER_W-1:0] count_next;
  logic running_reg;
  logic running_next;
  logic expired_reg;
  logic expired_next;

  // Loads on start, counts to one, then pulses expired.
  always_comb begin
    count_next = count_reg;
    running_next = running_reg;
    expired_next = 1'b0;
    if (start) begin
      count_next = (limit == '0) ? TIMER_W'(1) : limit;
      running_next = 1'b1;
    end else if (running_reg) begin
      if (count_reg == TIMER_W'(1)) begin
        running_next = 1'b0;
        expired_next = 1'b1;
      end else begin
        count_next = count_reg - TIMER_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_reg <= '0;
      running_reg <= 1'b0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      running_reg <= running_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule

//--- verilog/active_antenna_supervisor.sv
// Active antenna supervisor: feed cut-off control, short and open sensing, status reports.
// Assumes sense inputs are synchronous to clk_sys and pull-ups sit at the pins.
//
// What this block does
// RL1: Each feature turns on only when its enable bit is written one; power-down on short also turns on with auto recovery.
// RL2: Feed cut-off output is active high; low while the antenna is powered.
// RL3: Short sense is active low, pulled up; the circuit pulls it low on short.
// RL4: Presence sense is active high, pulled up; pulled low when no current drawn.
// RL5: Short without power-down reports SHORT and keeps cut-off low.
// RL6: Without auto recovery a detected short stays reported after sense returns high.
// RL7: Latched short clears only by power cycle, short detect off then on, or feed voltage control off then on.
// RL8: With auto recovery the short status may recover after a timeout.
// RL9: With auto recovery a short reports SHORT, power off, cut-off high.
// RL10: After the timeout, drive cut-off low and resample short sense.
// RL11: Retest without short reports OK, power on; otherwise back to shorted off.
// RL12: With open detection a low presence sense reports OPEN.
// RL13: With open detection a high or floating presence sense reports OK.
// RL14: At start-up emit capability report, then INIT, then OK without fault.
// RL15: Capability report lists one code per enabled feature.
// RL16: No status reports unless feed voltage control is enabled.
// RL17: Recovery timeout is a configurable cycle counter.
module active_antenna_supervisor
  import antenna_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Antenna pins
  input wire logic feed_short_sense_low,
  input wire logic feed_present_sense,
  output logic feed_cut_out,
  // Reports and interrupt
  output feed_report_t feed_status_report,
  output logic irq
);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_CAPS,
    ST_INIT,
    ST_RUN,
    ST_SHORT_HOLD,
    ST_SHORT_CUT,
    ST_RETEST
  } sup_state_t;

  // Register file state.
  feature_cfg_t cfg_reg;
  feature_cfg_t cfg_next;
  logic [TIMER_W-1:0] timeout_reg;
  logic [TIMER_W-1:0] timeout_next;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_mask_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Supervisor state.
  sup_state_t state_reg;
  sup_state_t state_next;
  feed_status_t status_reg;
  feed_status_t status_next;
  logic cut_reg;
  logic cut_next;
  feed_report_t report_reg;
  feed_report_t report_next;
  logic timer_start;
  logic [TIMER_W-1:0] timer_limit;
  logic timer_expired;
  logic [IRQ_W-1:0] events;

  logic short_sensed;
  logic antenna_missing;
  logic cut_enable;
  feature_cfg_t caps;

  // Short and presence sense polarity.
  // RL3: Active low short.
  assign short_sensed = ~feed_short_sense_low;
  // RL4: Active high presence.
  assign antenna_missing = ~feed_present_sense;

  // Power-down on short is taken when either power-down or recovery is on.
  assign cut_enable = (cfg_reg.power_down_on_short == CFG_ON) ||
                      (cfg_reg.short_auto_recovery_enable == CFG_ON);

  // RL15: Capability codes per feature.
  assign caps = cfg_reg;

  supervisor_timer recovery_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(timer_start),
    .limit(timer_limit),
    .expired(timer_expired)
  );

  // Register writes, reads and interrupt status.
  always_comb begin
    cfg_next = cfg_reg;
    timeout_next = timeout_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    rdata_next = '0;
    if (reg_wr) begin
      case (reg_addr)
        // RL1: Enables written as one.
        CTRL_OFFSET: cfg_next = feature_cfg_t'(reg_wdata[CFG_W-1:0]);
        // RL17: Timeout count.
        TIMEOUT_OFFSET: timeout_next = reg_wdata[TIMER_W-1:0];
        IRQ_MASK_OFFSET: irq_mask_next = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        CTRL_OFFSET: rdata_next = DATA_W'(cfg_reg);
        TIMEOUT_OFFSET: rdata_next = DATA_W'(timeout_reg);
        STATUS_OFFSET: begin
          rdata_next[STAT_CODE_LSB +: 2] = status_reg;
          rdata_next[STAT_POWER_BIT] = ~cut_reg;
          rdata_next[STAT_CUT_BIT] = cut_reg;
        end
        CAPS_OFFSET: rdata_next = DATA_W'(caps);
        IRQ_STATUS_OFFSET: begin
          rdata_next = DATA_W'(irq_status_reg);
          irq_status_next = '0;
        end
        IRQ_MASK_OFFSET: rdata_next = DATA_W'(irq_mask_reg);
        default: rdata_next = '0;
      endcase
    end
    // A new event wins over the read clear.
    irq_status_next = irq_status_next | events;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg_reg <= CFG_RESET;
      timeout_reg <= RECOVERY_CYCLES_RESET;
      irq_status_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
      rdata_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      timeout_reg <= timeout_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // Supervisor sequence, cut-off control and reports.
  always_comb begin
    state_next = state_reg;
    status_next = status_reg;
    cut_next = cut_reg;
    timer_start = 1'b0;
    timer_limit = timeout_reg;
    events = '0;
    report_next = '0;
    report_next.caps = caps;
    report_next.status = status_reg;
    case (state_reg)
      ST_OFF: begin
        cut_next = 1'b0;
        status_next = FEED_INIT;
        if (cfg_reg.feed_voltage_control_enable == CFG_ON) begin
          state_next = ST_CAPS;
        end
      end
      ST_CAPS: begin
        // RL14: Capability report first.
        report_next.valid = 1'b1;
        report_next.kind = REPORT_CAPABILITY;
        state_next = ST_INIT;
      end
      ST_INIT: begin
        // RL14: INIT status next.
        report_next.valid = 1'b1;
        report_next.kind = REPORT_STATUS;
        report_next.status = FEED_INIT;
        status_next = FEED_INIT;
        state_next = ST_RUN;
      end
      ST_RUN: begin
        // RL2: Feed powered, cut-off low.
        cut_next = 1'b0;
        if ((cfg_reg.short_detect_enable == CFG_ON) && short_sensed) begin
          status_next = FEED_SHORT;
          events[IRQ_SHORT_SEEN] = 1'b1;
          if (cut_enable) begin
            // RL9: Power off on short.
            cut_next = 1'b1;
            state_next = ST_SHORT_CUT;
            timer_start = 1'b1;
          end else begin
            // RL5: Report only, power stays on.
            state_next = ST_SHORT_HOLD;
          end
        end else if ((cfg_reg.open_detect_enable == CFG_ON) && antenna_missing) begin
          // RL12: Open reported.
          status_next = FEED_OPEN;
        end else begin
          // RL13: Present or floating is OK.
          status_next = FEED_OK;
        end
      end
      ST_SHORT_HOLD: begin
        // RL6: Short stays latched.
        cut_next = 1'b0;
        status_next = FEED_SHORT;
        if (cfg_reg.short_detect_enable != CFG_ON) begin
          // RL7: Disable clears the latch.
          state_next = ST_RUN;
        end else if (cut_enable) begin
          cut_next = 1'b1;
          state_next = ST_SHORT_CUT;
          timer_start = 1'b1;
        end
      end
      ST_SHORT_CUT: begin
        status_next = FEED_SHORT;
        cut_next = 1'b1;
        if (cfg_reg.short_detect_enable != CFG_ON) begin
          // RL7: Disable clears the latch.
          cut_next = 1'b0;
          state_next = ST_RUN;
        end else if ((cfg_reg.short_auto_recovery_enable == CFG_ON) && timer_expired) begin
          // RL8: Timeout allows recovery.
          // RL10: Cut-off low for the retest.
          cut_next = 1'b0;
          state_next = ST_RETEST;
          timer_start = 1'b1;
          timer_limit = RETEST_SETTLE_CYCLES;
        end
      end
      ST_RETEST: begin
        cut_next = 1'b0;
        if (timer_expired) begin
          // RL10: Resample the short sense.
          if (short_sensed && (cfg_reg.short_detect_enable == CFG_ON)) begin
            // RL11: Still shorted, back off.
            cut_next = 1'b1;
            state_next = ST_SHORT_CUT;
            timer_start = 1'b1;
          end else begin
            // RL11: Recovered, report OK.
            status_next = FEED_OK;
            events[IRQ_RECOVERED] = 1'b1;
            state_next = ST_RUN;
          end
        end
      end
      default: begin
        state_next = ST_OFF;
        cut_next = 1'b0;
      end
    endcase
    // RL16: No reporting without voltage control.
    if (cfg_reg.feed_voltage_control_enable != CFG_ON) begin
      state_next = ST_OFF;
      cut_next = 1'b0;
      status_next = FEED_INIT;
      report_next.valid = 1'b0;
    end else if ((state_reg != ST_OFF) && (state_reg != ST_CAPS) && (state_reg != ST_INIT) &&
                 (status_next != status_reg)) begin
      report_next.valid = 1'b1;
      report_next.kind = REPORT_STATUS;
      report_next.status = status_next;
      events[IRQ_STATUS_CHANGE] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_OFF;
      status_reg <= FEED_INIT;
      cut_reg <= 1'b0;
      report_reg <= '0;
    end else begin
      state_reg <= state_next;
      status_reg <= status_next;
      cut_reg <= cut_next;
      report_reg <= report_next;
    end
  end

  assign feed_cut_out = cut_reg;
  assign feed_status_report = report_reg;
  assign reg_rdata = rdata_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

//--- sim/antenna_bias_model.sv
// Behavioural antenna bias and sense circuit at the far side of the supervisor.
// Assumes the bench asks for a shorted or a missing antenna by level.
module antenna_bias_model (
  // Feed control from the supervisor
  input wire logic feed_cut_out,
  // Fault requests from the bench
  input wire logic short_req,
  input wire logic absent_req,
  // Sense lines, pulled up unless driven low
  output logic feed_short_sense_low,
  output logic feed_present_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  // short pulls low
  // A cut feed carries no current, so a short shows only while powered.
  assign feed_short_sense_low = !(short_req && !feed_cut_out);
  assign feed_present_sense = !absent_req;
endmodule

//--- sim/supervisor_monitor.sv
// Concurrent checks on the ports of the antenna supervisor.
// Assumes one clock, clk_sys, and the synchronous active-low reset nrst.
module supervisor_monitor
  import antenna_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Antenna pins, reports and interrupt
  input wire logic feed_short_sense_low,
  input wire logic feed_present_sense,
  input wire logic feed_cut_out,
  input wire feed_report_t feed_status_report,
  input wire logic irq
);
  feature_cfg_t cfg;
  logic [2:0] quiet;
  feed_status_t last;
  feed_report_t r;
  logic rec;
  logic sd_run;
  assign r = feed_status_report;
  assign rec = cfg.short_auto_recovery_enable;
  assign sd_run = cfg.short_detect_enable && last == FEED_OK;

  // Tracks the enables, the time since a control write and the last status reported.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg <= CFG_RESET;
      quiet <= 3'h0;
      last <= FEED_INIT;
    end else begin
      if (reg_wr && reg_addr == CTRL_OFFSET) begin
        cfg <= feature_cfg_t'(reg_wdata[CFG_W-1:0]);
        quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
      if (!cfg.feed_voltage_control_enable) begin
        last <= FEED_INIT;
      end else if (r.valid && r.kind == REPORT_STATUS) begin
        last <= r.status;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_cap;
    r.valid && r.kind == REPORT_CAPABILITY && r.caps == cfg;
  endsequence
  sequence s_init;
    r.valid && r.kind == REPORT_STATUS && r.status == FEED_INIT;
  endsequence
  sequence s_settle;
    $fell(feed_cut_out) && rec && quiet == 3'h7;
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside a read");
  a_off_quiet: assert property (
    !cfg.feed_voltage_control_enable && quiet == 3'h7 |-> !feed_cut_out && !r.valid)
    else $error("activity with voltage control off");
  a_startup_order: assert property (
    $rose(cfg.feed_voltage_control_enable) |-> ##[1:2] s_cap ##1 s_init ##1 (r.valid && r.kind == REPORT_STATUS))
    else $error("start-up reports out of order");
  a_short_keep_on: assert property (
    sd_run && !cfg.power_down_on_short && !rec && $fell(feed_short_sense_low)
    |-> ##1 (r.valid && r.status == FEED_SHORT && !feed_cut_out))
    else $error("short without power-down mishandled");
  a_short_latched: assert property (
    !rec && cfg.short_detect_enable && quiet == 3'h7 && last == FEED_SHORT |-> !(r.valid && r.status != FEED_SHORT))
    else $error("latched short status cleared");
  a_short_cut_off: assert property (
    sd_run && rec && $fell(feed_short_sense_low) |-> ##1 (r.valid && r.status == FEED_SHORT && feed_cut_out))
    else $error("short with recovery did not cut the feed");
  a_retest_hold: assert property (s_settle |-> !feed_cut_out [*8])
    else $error("retest did not hold the feed on");
  a_retest_result: assert property (
    s_settle |-> ##[8:30] (feed_cut_out || (r.valid && r.status == FEED_OK)))
    else $error("retest gave no outcome");
  a_open_report: assert property (
    cfg.open_detect_enable && last == FEED_OK && feed_short_sense_low && $fell(feed_present_sense)
    |-> ##1 (r.valid && r.status == FEED_OPEN))
    else $error("open antenna not reported");
  a_open_clear: assert property (
    cfg.open_detect_enable && quiet == 3'h7 && last == FEED_OPEN && feed_short_sense_low && $rose(feed_present_sense)
    |-> ##1 (r.valid && r.status == FEED_OK))
    else $error("antenna return not reported");
endmodule

bind active_antenna_supervisor supervisor_monitor mon_u (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .feed_short_sense_low, .feed_present_sense, .feed_cut_out, .feed_status_report, .irq);

//--- sim/testbench.sv
// Self-checking bench for the antenna supervisor with a behavioural bias circuit.
// Assumes a 20 MHz clock; expected reads and reports are queued by the driver.
module testbench
  import antenna_supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, short_req = 0, absent_req = 0, rd_d = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, tmo;
  logic feed_short_sense_low, feed_present_sense, feed_cut_out, irq;
  feed_report_t rep;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [DATA_W-1:0] rd_q[$];
  logic [7:0] rep_q[$];

  active_antenna_supervisor dut_u (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .feed_short_sense_low, .feed_present_sense, .feed_cut_out, .feed_status_report(rep), .irq);
  antenna_bias_model far_u (.feed_cut_out, .short_req, .absent_req, .feed_short_sense_low, .feed_present_sense);

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    if (e === 'x) return;
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic idle(input int n);
    reg_wr <= 0;
    reg_rd <= 0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_wr <= 1;
    reg_rd <= 0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_rd <= 1;
    reg_wr <= 0;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk_sys);
  endtask

  task automatic ex(input feed_status_t s);
    rep_q.push_back({1'b1, s, 5'h00});
  endtask

  task automatic wait_q;
    for (int i = 0; i < 300 && rep_q.size() > 0; i++) @(posedge clk_sys);
    chk("pending reports", 32'h0, rep_q.size());
  endtask

  // Restarts the supervisor with the given enables and expects the start-up reports.
  task automatic boot(input logic [4:0] c);
    wr(CTRL_OFFSET, 32'h0);
    idle(3);
    rep_q.push_back({1'b0, 2'h0, c});
    ex(FEED_INIT);
    ex(FEED_OK);
    wr(CTRL_OFFSET, {27'h0, c});
    idle(8);
    wait_q();
  endtask

  // Compares read data and reports against the oldest queued expectation.
  always @(posedge clk_sys) begin
    if (rd_d) chk("reg_rdata", rd_q.pop_front(), reg_rdata);
    rd_d <= reg_rd;
    if (rep.valid === 1'b1) begin
      chk("report", rep_q.size() > 0 ? {24'h0, rep_q.pop_front()} : 32'hDEAD,
        rep.kind == REPORT_STATUS ? {1'b1, rep.status, 5'h00} : {1'b0, 2'h0, rep.caps});
    end
    if (++cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(37));
    tmo = $urandom_range(20, 5);
    repeat (2) @(posedge clk_sys);
    nrst <= 1;
    idle(2);
    chk("feed_cut_out", 0, feed_cut_out);
    chk("irq", 0, irq);
    rd(CTRL_OFFSET, 32'h0);
    rd(TIMEOUT_OFFSET, RECOVERY_CYCLES_RESET);
    rd(STATUS_OFFSET, 32'h4);
    wr(CAPS_OFFSET, 32'h1F);
    rd(CAPS_OFFSET, 32'h0);
    wr(8'h18, 32'h1F);
    rd(8'h18, 32'h0);
    boot(5'h01);
    rd(CAPS_OFFSET, 32'h1);
    rd(STATUS_OFFSET, 32'h5);
    short_req <= 1;
    idle(10);
    short_req <= 0;
    boot(5'h03);
    rd(IRQ_STATUS_OFFSET, 32'h1);
    wr(IRQ_MASK_OFFSET, 32'h2);
    ex(FEED_SHORT);
    short_req <= 1;
    idle(4);
    chk("feed_cut_out", 0, feed_cut_out);
    chk("irq", 1, irq);
    short_req <= 0;
    idle(4);
    rd(STATUS_OFFSET, 32'h6);
    rd(IRQ_STATUS_OFFSET, 32'h3);
    idle(1);
    chk("irq", 0, irq);
    ex(FEED_OK);
    wr(CTRL_OFFSET, 32'h1);
    idle(3);
    wr(CTRL_OFFSET, 32'h3);
    idle(4);
    wait_q();
    rd(STATUS_OFFSET, 32'h5);
    idle(1);
    chk("irq", 0, irq);
    wr(TIMEOUT_OFFSET, tmo);
    boot(5'h1F);
    ex(FEED_SHORT);
    short_req <= 1;
    idle(3);
    chk("feed_cut_out", 1, feed_cut_out);
    rd(STATUS_OFFSET, 32'hA);
    idle(3 * (tmo + 25));
    ex(FEED_OK);
    short_req <= 0;
    idle(tmo + 40);
    wait_q();
    chk("feed_cut_out", 0, feed_cut_out);
    rd(IRQ_STATUS_OFFSET, 32'h7);
    boot(5'h0B);
    ex(FEED_SHORT);
    short_req <= 1;
    idle(2 * tmo + 30);
    short_req <= 0;
    idle(4);
    chk("feed_cut_out", 1, feed_cut_out);
    rd(STATUS_OFFSET, 32'hA);
    boot(5'h05);
    ex(FEED_OPEN);
    absent_req <= 1;
    idle($urandom_range(9, 3));
    ex(FEED_OK);
    absent_req <= 0;
    idle(4);
    wait_q();
    rd(STATUS_OFFSET, 32'h5);
    idle(3);
    complete_run();
  end
endmodule
